/* File: rtl/sdl_pkg.sv */
// sdl_pkg: shared constants for the serial dac load link (device end and host end).
// assumes a 50 MHz clk_sys on both ends; link times are in ns and turned into clk_sys cycles.
package sdl_pkg;

  localparam int WORD_W = 16;
  localparam int SEG_W = 15;
  localparam int LADDER_W = 12;
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam logic [4:0] CNT_LAST = 5'h0f;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [3:0] BIT_LAST = 4'hf;

  localparam int CLK_NS = 20;
  localparam int SCLK_HALF_NS = 200;
  localparam int SETUP_NS = 40;
  localparam int TAIL_NS = 40;
  localparam int GAP_NS = 40;
  localparam int LOAD_PULSE_NS = 40;

  // least times, rounded up to whole cycles
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAIL_CYC = (TAIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_CYC = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;

endpackage : sdl_pkg

/* File: rtl/sdl_link_if.sv */
// sdl_link_if: the serial pins between one host and one device.
// the open-drain data output is resolved here with an assumed pull-up.
`timescale 1ns/1ps
interface sdl_link_if;
  logic sclk;
  logic frame_n;
  logic load_strobe_n;
  logic serial_in;
  logic sdo_o;
  logic sdo_oe;
  logic clear_output_n;
  logic power_down_n;
  logic serial_out;

  // released line floats high through the external pull-up
  assign serial_out = sdo_oe ? sdo_o : 1'h1;

  modport device (
    input sclk, frame_n, load_strobe_n, serial_in, clear_output_n, power_down_n,
    output sdo_o, sdo_oe
  );
  modport host (
    output sclk, frame_n, load_strobe_n, serial_in, clear_output_n, power_down_n,
    input serial_out
  );
endinterface : sdl_link_if

/* File: rtl/sdl_dev.sv */
// sdl_dev: digital load logic of one 16-bit serial dac: shift register on the link clock,
// input and dac registers plus segment decode on clk_sys.
// assumes frame_n and serial_in change only while sclk is high (host derives all three
// from one clock), and that sclk stops or is ignored while frame_n is high.
`timescale 1ns/1ps
module sdl_dev #(
  parameter int WORD_W = sdl_pkg::WORD_W
) (
  sdl_link_if.device lnk,               // serial pins
  input wire logic clk_sys,             // system clock, 50 MHz
  input wire logic reset,               // synchronous, active high
  output logic [15:0] dac_code,         // dac register
  output logic [14:0] seg_sel,          // thermometer segment selects
  output logic [11:0] ladder_sel,       // binary ladder switch controls
  output logic signed [15:0] out_level, // output in steps, zero at midscale
  output logic out_grounded,            // output forced to analog ground
  output logic powered_down             // power-down pin seen low
);

  function automatic logic [14:0] therm(input logic [3:0] v);
    logic [14:0] t;
    t = '0;
    for (int i = 0; i < sdl_pkg::SEG_W; i++) begin
      t[i] = (4'(i) < v);
    end
    return t;
  endfunction : therm

  // ---------------- link domain (falling edge of sclk) ----------------
  logic link_rst_r;
  logic [4:0] cnt_r;
  logic [WORD_W-1:0] sh_r;
  logic word_tgl_r;
  logic sdo_oe_r;
  logic [15:0] dac_r;
  logic frame_clr;

  // frame high clears the per-frame state at once, since sclk may be stopped then
  assign frame_clr = lnk.frame_n | link_rst_r;

  always_ff @(negedge lnk.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != sdl_pkg::CNT_FULL) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // preset only while reset is held: sclk idles then, so the preset cannot race a shift
  always_ff @(negedge lnk.sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      sh_r <= WORD_W'(sdl_pkg::MIDSCALE);
    end else if (!lnk.frame_n) begin
      sh_r <= {sh_r[WORD_W-2:0], lnk.serial_in};
    end
  end

  // one toggle per frame that completed at least one word
  always_ff @(negedge lnk.sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      word_tgl_r <= 1'h0;
    end else if (!lnk.frame_n && cnt_r == sdl_pkg::CNT_LAST) begin
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // open drain: pull low for a zero. dac_r is quasi-static here: it only changes while
  // frame_n is high, and this logic is held cleared then.
  always_ff @(negedge lnk.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      sdo_oe_r <= 1'h0;
    end else if (cnt_r >= sdl_pkg::CNT_LAST) begin
      sdo_oe_r <= ~sh_r[WORD_W-2];
    end else begin
      sdo_oe_r <= ~dac_r[4'(sdl_pkg::CNT_LAST - cnt_r)];
    end
  end

  assign lnk.sdo_o = 1'h0;
  assign lnk.sdo_oe = sdo_oe_r;

  // ---------------- system domain ----------------
  logic frame_s1_r, frame_s2_r, frame_prev_r;
  logic load_s1_r, load_s2_r, load_prev_r;
  logic clr_s1_r, clr_s2_r, clr_prev_r;
  logic pd_s1_r, pd_s2_r;
  logic tgl_s1_r, tgl_s2_r, ack_r;
  logic [15:0] in_r;
  logic grounded_r;
  logic word_new, load_fall, clr_fall, dac_upd;
  logic [15:0] code_eff;

  always_ff @(posedge clk_sys) begin
    link_rst_r <= reset;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_s1_r <= 1'h1;
      frame_s2_r <= 1'h1;
      frame_prev_r <= 1'h1;
      load_s1_r <= 1'h1;
      load_s2_r <= 1'h1;
      load_prev_r <= 1'h1;
      clr_s1_r <= 1'h1;
      clr_s2_r <= 1'h1;
      clr_prev_r <= 1'h1;
      pd_s1_r <= 1'h1;
      pd_s2_r <= 1'h1;
      tgl_s1_r <= 1'h0;
      tgl_s2_r <= 1'h0;
    end else begin
      frame_s1_r <= lnk.frame_n;
      frame_s2_r <= frame_s1_r;
      frame_prev_r <= frame_s2_r;
      load_s1_r <= lnk.load_strobe_n;
      load_s2_r <= load_s1_r;
      load_prev_r <= load_s2_r;
      clr_s1_r <= lnk.clear_output_n;
      clr_s2_r <= clr_s1_r;
      clr_prev_r <= clr_s2_r;
      pd_s1_r <= lnk.power_down_n;
      pd_s2_r <= pd_s1_r;
      tgl_s1_r <= word_tgl_r;
      tgl_s2_r <= tgl_s1_r;
    end
  end

  // the toggle flips at the sixteenth edge, at least one tail time before frame_n rises,
  // so with equal synchroniser depth it is always seen by the time the rise is
  assign word_new = frame_s2_r && !frame_prev_r && (tgl_s2_r != ack_r);
  assign load_fall = !load_s2_r && load_prev_r && frame_s2_r;
  assign clr_fall = !clr_s2_r && clr_prev_r;
  assign dac_upd = (word_new && !load_s2_r) || load_fall;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_r <= 1'h0;
    end else if (word_new) begin
      ack_r <= tgl_s2_r;
    end
  end

  // sh_r is stable here: it shifts only while frame_n is low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_r <= sdl_pkg::MIDSCALE;
    end else if (word_new) begin
      in_r <= sh_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dac_r <= sdl_pkg::MIDSCALE;
    end else if (word_new && !load_s2_r) begin
      dac_r <= sh_r;
    end else if (load_fall) begin
      dac_r <= in_r;
    end
  end

  // a new dac value releases the clamp only once clear is back high; a clear edge wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      grounded_r <= 1'h0;
    end else if (clr_fall) begin
      grounded_r <= 1'h1;
    end else if (dac_upd && clr_s2_r) begin
      grounded_r <= 1'h0;
    end
  end

  // grounded output is the midscale level; registers keep their content
  assign code_eff = grounded_r ? sdl_pkg::MIDSCALE : dac_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seg_sel <= therm(sdl_pkg::MIDSCALE[15:12]);
      ladder_sel <= sdl_pkg::MIDSCALE[11:0];
      out_level <= 16'h0000;
      out_grounded <= 1'h0;
      powered_down <= 1'h0;
      dac_code <= sdl_pkg::MIDSCALE;
    end else begin
      seg_sel <= therm(code_eff[15:12]);
      ladder_sel <= code_eff[11:0];
      out_level <= $signed(code_eff ^ sdl_pkg::MIDSCALE);
      out_grounded <= grounded_r;
      powered_down <= ~pd_s2_r;
      dac_code <= dac_r;
    end
  end

endmodule : sdl_dev

/* File: rtl/sdl_host.sv */
// sdl_host: serial master for a chain of dacs; sends words msb first and captures
// what comes back on serial_out, one received word per sent word.
// assumes the user holds word_valid/word_data/word_last until word_ack.
`timescale 1ns/1ps
module sdl_host (
  sdl_link_if.host lnk,           // serial pins
  input wire logic clk_sys,       // system clock, 50 MHz
  input wire logic reset,         // synchronous, active high
  input wire logic word_valid,    // a word is offered
  input wire logic [15:0] word_data, // word to send
  input wire logic word_last,     // last word of this frame
  input wire logic mode_async,    // 1: load strobe high while shifting
  input wire logic load_after,    // async mode: pulse load strobe after frame
  input wire logic clear_req,     // drive clear pin low
  input wire logic power_down_req, // drive power-down pin low
  output logic word_ack,          // pulse: word taken
  output logic rx_valid,          // pulse: rx_data holds a word
  output logic [15:0] rx_data,    // word shifted back from the chain
  output logic busy               // frame or load in progress
);

  typedef enum {ST_IDLE, ST_SETUP, ST_LO, ST_HI, ST_WAIT, ST_TAIL, ST_GAP, ST_LOAD}
    sdl_host_st_e;

  sdl_host_st_e st_r;
  logic [7:0] tmr_r;
  logic [3:0] bit_r;
  logic [15:0] tx_r;
  logic [15:0] rx_r;
  logic last_r, async_r, load_r;
  logic sclk_r, frame_r, load_strobe_n_r, sdi_r, clr_r, pd_r;
  logic so_s1_r, so_s2_r;
  logic tmr_done;

  assign tmr_done = (tmr_r == 8'h00);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      so_s1_r <= 1'h1;
      so_s2_r <= 1'h1;
      clr_r <= 1'h1;
      pd_r <= 1'h1;
    end else begin
      so_s1_r <= lnk.serial_out;
      so_s2_r <= so_s1_r;
      clr_r <= ~clear_req;
      pd_r <= ~power_down_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= ST_IDLE;
      tmr_r <= 8'h00;
      bit_r <= 4'h0;
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      last_r <= 1'h0;
      async_r <= 1'h1;
      load_r <= 1'h0;
      sclk_r <= 1'h1;
      frame_r <= 1'h1;
      load_strobe_n_r <= 1'h1;
      sdi_r <= 1'h0;
      word_ack <= 1'h0;
      rx_valid <= 1'h0;
      rx_data <= 16'h0000;
      busy <= 1'h0;
    end else begin
      word_ack <= 1'h0;
      rx_valid <= 1'h0;
      if (!tmr_done) begin
        tmr_r <= tmr_r - 8'h01;
      end
      case (st_r)
        ST_IDLE: begin
          load_strobe_n_r <= mode_async;
          busy <= 1'h0;
          if (word_valid) begin
            tx_r <= {word_data[14:0], 1'h0};
            sdi_r <= word_data[15];
            last_r <= word_last;
            async_r <= mode_async;
            load_r <= load_after;
            word_ack <= 1'h1;
            frame_r <= 1'h0;
            busy <= 1'h1;
            bit_r <= 4'h0;
            tmr_r <= 8'(sdl_pkg::SETUP_CYC - 1);
            st_r <= ST_SETUP;
          end
        end
        ST_SETUP, ST_HI: begin
          if (tmr_done) begin
            sclk_r <= 1'h0;
            tmr_r <= 8'(sdl_pkg::SCLK_HALF_CYC - 1);
            st_r <= ST_LO;
          end
        end
        ST_LO: begin
          if (tmr_done) begin
            // data moves on the rising edge, a half period before the device samples
            sclk_r <= 1'h1;
            rx_r <= {rx_r[14:0], so_s2_r};
            sdi_r <= tx_r[15];
            tx_r <= {tx_r[14:0], 1'h0};
            bit_r <= bit_r + 4'h1;
            tmr_r <= 8'(sdl_pkg::SCLK_HALF_CYC - 1);
            st_r <= ST_HI;
            if (bit_r == sdl_pkg::BIT_LAST) begin
              rx_valid <= 1'h1;
              rx_data <= {rx_r[14:0], so_s2_r};
              st_r <= last_r ? ST_TAIL : ST_WAIT;
              tmr_r <= 8'(sdl_pkg::TAIL_CYC - 1);
            end
          end
        end
        ST_WAIT: begin
          // burst clock: sclk held high until the next word of the chain arrives
          if (word_valid) begin
            sdi_r <= word_data[15];
            tx_r <= {word_data[14:0], 1'h0};
            last_r <= word_last;
            word_ack <= 1'h1;
            tmr_r <= 8'(sdl_pkg::SCLK_HALF_CYC - 1);
            st_r <= ST_HI;
          end
        end
        ST_TAIL: begin
          if (tmr_done) begin
            frame_r <= 1'h1;
            tmr_r <= 8'(sdl_pkg::GAP_CYC - 1);
            st_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tmr_done) begin
            if (async_r && load_r) begin
              load_strobe_n_r <= 1'h0;
              load_r <= 1'h0;
              tmr_r <= 8'(sdl_pkg::LOAD_CYC - 1);
              st_r <= ST_LOAD;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_LOAD: begin
          if (tmr_done) begin
            load_strobe_n_r <= 1'h1;
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_r;
  assign lnk.frame_n = frame_r;
  assign lnk.load_strobe_n = load_strobe_n_r;
  assign lnk.serial_in = sdi_r;
  assign lnk.clear_output_n = clr_r;
  assign lnk.power_down_n = pd_r;

endmodule : sdl_host

/* File: verif/sdl_link_checker.sv */
// sdl_link_checker: wire-level properties of one host-to-device link.
// assumes the link signals and the clk_sys/reset that time the host.
`timescale 1ns/1ps
module sdl_link_checker (
  input wire logic clk_sys,       // system clock
  input wire logic reset,         // synchronous, active high
  input wire logic sclk,          // link clock
  input wire logic frame_n,       // frame strobe
  input wire logic load_strobe_n, // load strobe
  input wire logic serial_in,     // data to device
  input wire logic sdo_o,         // device drive value
  input wire logic sdo_oe         // device pulls line low
);
  logic sclk_d_r;
  logic [7:0] fall_cnt_r;

  always_ff @(posedge clk_sys) begin
    sclk_d_r <= sclk;
  end

  // falls seen in the current frame; cleared while the frame is closed
  always_ff @(posedge clk_sys) begin
    if (reset || frame_n) begin
      fall_cnt_r <= 8'h00;
    end else if (sclk_d_r && !sclk) begin
      fall_cnt_r <= fall_cnt_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_sdo_released: assert property (frame_n && $past(frame_n) |-> !sdo_oe)
    else $error("serial out driven outside a frame");
  a_sdo_open_drain: assert property (sdo_oe |-> !sdo_o && !frame_n)
    else $error("serial out driven high or outside a frame");
  a_sdo_on_fall: assert property ($changed(sdo_oe) |-> $fell(sclk) || $rose(frame_n))
    else $error("serial out moved off a falling edge");
  a_data_hold: assert property ($changed(serial_in) |-> sclk)
    else $error("serial in moved while clock low");
  a_frame_setup: assert property ($fell(frame_n) |-> sclk [*2])
    else $error("clock fell too soon after frame start");
  a_clock_idle: assert property (frame_n |-> sclk)
    else $error("clock low outside a frame");
  a_half_period: assert property ($fell(sclk) |-> (!sclk) [*8] ##1 (!sclk) [*2] ##1 sclk)
    else $error("clock low phase not ten cycles");
  a_tail_time: assert property ($rose(frame_n) |-> $past(sclk) && $past(sclk, 2))
    else $error("frame closed too soon after last edge");
  a_whole_words: assert property (
    $rose(frame_n) |-> fall_cnt_r != 8'h00 && fall_cnt_r[3:0] == 4'h0)
    else $error("frame not a whole number of words");
  a_load_steady: assert property (!frame_n |-> $stable(load_strobe_n))
    else $error("load strobe moved inside a frame");
endmodule : sdl_link_checker

/* File: verif/test_serial_dac_load_interface.sv */
// test_serial_dac_load_interface: one host driving a chain of two devices.
// assumes the package, link interface and both design modules are compiled first.
`timescale 1ns/1ps
module test_serial_dac_load_interface;
  logic clk_sys, reset, word_valid, word_last, mode_async, load_after;
  logic clear_req, power_down_req, word_ack, rx_valid, busy;
  logic [15:0] word_data, rx_data, dac_a, dac_b, lvl_a, lvl_b;
  logic [14:0] seg_a, seg_b;
  logic [11:0] lad_a, lad_b;
  logic gnd_a, gnd_b, pd_a, pd_b;
  logic [15:0] rxq[$];
  int n_fail, samples_checked;

  sdl_link_if lnk_a();
  sdl_link_if lnk_b();
  // second device shares every control line; its data comes from the first
  assign lnk_b.sclk = lnk_a.sclk;
  assign lnk_b.frame_n = lnk_a.frame_n;
  assign lnk_b.load_strobe_n = lnk_a.load_strobe_n;
  assign lnk_b.clear_output_n = lnk_a.clear_output_n;
  assign lnk_b.power_down_n = lnk_a.power_down_n;
  assign lnk_b.serial_in = lnk_a.serial_out;

  sdl_host sdl_host_inst (.lnk(lnk_a), .clk_sys(clk_sys), .reset(reset),
    .word_valid(word_valid), .word_data(word_data), .word_last(word_last),
    .mode_async(mode_async), .load_after(load_after), .clear_req(clear_req),
    .power_down_req(power_down_req), .word_ack(word_ack), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy));
  sdl_dev sdl_dev_inst (.lnk(lnk_a), .clk_sys(clk_sys), .reset(reset), .dac_code(dac_a),
    .seg_sel(seg_a), .ladder_sel(lad_a), .out_level(lvl_a), .out_grounded(gnd_a),
    .powered_down(pd_a));
  sdl_dev sdl_dev_inst_b (.lnk(lnk_b), .clk_sys(clk_sys), .reset(reset), .dac_code(dac_b),
    .seg_sel(seg_b), .ladder_sel(lad_b), .out_level(lvl_b), .out_grounded(gnd_b),
    .powered_down(pd_b));
  sdl_link_checker sdl_link_checker_inst (.clk_sys(clk_sys), .reset(reset),
    .sclk(lnk_a.sclk), .frame_n(lnk_a.frame_n), .load_strobe_n(lnk_a.load_strobe_n),
    .serial_in(lnk_a.serial_in), .sdo_o(lnk_a.sdo_o), .sdo_oe(lnk_a.sdo_oe));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp);
    check_val({15'h0000, got}, {15'h0000, exp});
  endtask : check_bit

  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // holds the offer until the host acknowledges it
  task automatic send_word(input logic [15:0] w, input logic last);
    int k;
    cyc(1);
    word_valid = 1'b1;
    word_data = w;
    word_last = last;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (word_ack !== 1'b1 && k < 2000);
    check_bit(word_ack, 1'b1);
    word_valid = 1'b0;
  endtask : send_word

  // one frame of two words, one per chained device
  task automatic xfer(input logic [15:0] w0, input logic [15:0] w1);
    int k;
    rxq.delete();
    send_word(w0, 1'b0);
    send_word(w1, 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      cyc(1);
      k++;
    end
    check_bit(busy, 1'b0);
    cyc(8);
  endtask : xfer

  task automatic t_reset;
    check_val(dac_a, 16'h8000);
    check_val(dac_b, 16'h8000);
    check_val({1'b0, seg_a}, 16'h00ff);
    check_val({4'h0, lad_a}, 16'h0000);
    check_val(lvl_a, 16'h0000);
    check_bit(lnk_a.serial_out, 1'b1);
  endtask : t_reset

  task automatic t_sync;
    xfer(16'ha5c3, 16'hf00f);
    check_val(dac_b, 16'ha5c3);
    check_val(dac_a, 16'hf00f);
    check_val({1'b0, seg_a}, 16'h7fff);
    check_val({1'b0, seg_b}, 16'h03ff);
    check_val({4'h0, lad_b}, 16'h05c3);
    check_val(lvl_a, 16'h700f);
    check_val(rxq[0], 16'h8001);
    check_val(rxq[1], 16'h4b87);
  endtask : t_sync

  task automatic t_async;
    mode_async = 1'b1;
    cyc(3);
    xfer(16'h0000, 16'hffff);
    check_val(dac_a, 16'hf00f);
    check_val(dac_b, 16'ha5c3);
    check_val(rxq[0], 16'hf00e);
    check_val(rxq[1], 16'h0001);
    load_after = 1'b1;
    xfer(16'h0001, 16'h7fff);
    check_val(dac_a, 16'h7fff);
    check_val(dac_b, 16'h0001);
    check_val({1'b0, seg_a}, 16'h007f);
    check_val(lvl_a, 16'hffff);
    check_val(lvl_b, 16'h8001);
  endtask : t_async

  task automatic t_clear;
    clear_req = 1'b1;
    power_down_req = 1'b1;
    cyc(8);
    check_bit(gnd_a, 1'b1);
    check_bit(gnd_b, 1'b1);
    check_val(dac_a, 16'h7fff);
    check_val(lvl_a, 16'h0000);
    check_bit(pd_a, 1'b1);
    clear_req = 1'b0;
    power_down_req = 1'b0;
    cyc(8);
    check_bit(pd_b, 1'b0);
    xfer(16'h1111, 16'h2222);
    check_bit(gnd_a, 1'b0);
    check_val(dac_a, 16'h2222);
    check_val({4'h0, lad_a}, 16'h0222);
  endtask : t_clear

  initial begin
    reset = 1'b1;
    word_valid = 1'b0;
    word_data = 16'h0000;
    word_last = 1'b0;
    mode_async = 1'b0;
    load_after = 1'b0;
    clear_req = 1'b0;
    power_down_req = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    cyc(4);
    t_reset();
    t_sync();
    t_async();
    t_clear();
    test_done();
  end

  // four frames take about 3000 cycles; allow well over twice that
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule : test_serial_dac_load_interface
